// ---- hw/ldpc_norm_parity_pkg.sv ----
// Constants, types and helpers for the LDPC normalization, parity check and encode block.
// Assumes a single core clock and a simple word register port onto the scale table.
package ldpc_norm_parity_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [19:0] SCALE_TABLE_FIRST = 20'h10000;
	localparam logic [19:0] SCALE_TABLE_LAST = 20'h103FC;
	localparam int SCALE_DEPTH = 256;
	localparam int SCALE_AW = 8;
	localparam int SCALE_W = 5;
	// Sixteenths: 5'h0C is 0.75
	localparam int SCALE_FRAC = 4;
	localparam logic [4:0] SCALE_RESET = 5'h0C;

	// ------------------------------------------------------------
	// Datapath sizes
	// ------------------------------------------------------------
	localparam int MAX_LAYERS = 16;
	localparam int LAYER_W = 4;
	localparam int NLAYER_W = 5;
	localparam int Z_W = 16;
	localparam int LLR_W = 6;
	localparam int ACC_W = 16;
	localparam int ITER_W = 6;
	localparam int ENTRY_W = 12;
	localparam logic [11:0] FINAL_CHECK_MAX_ENTRIES = 12'h400;

	typedef logic [MAX_LAYERS-1:0][Z_W-1:0] par_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEC,
		ST_CHK,
		ST_ENC_LOAD,
		ST_ENC_P0,
		ST_ENC_SOLVE,
		ST_STAT
	} state_e;

	// Per-block factor in sixteenths: select 0..15 maps to 1/16..16/16
	function automatic logic [4:0] norm_from_select(input logic [3:0] sel);
		norm_from_select = {1'b0, sel} + 5'h01;
	endfunction : norm_from_select

	// XOR of every already known parity column flagged in the mask
	function automatic logic [15:0] masked_parity(input logic [15:0] mask, input par_t par);
		logic [15:0] acc;
		acc = 16'h0000;
		for (int j = 0; j < MAX_LAYERS; j++) begin
			if (mask[j]) begin
				acc = acc ^ par[j];
			end
		end
		masked_parity = acc;
	endfunction : masked_parity

endpackage : ldpc_norm_parity_pkg

// ---- hw/ldpc_norm_parity_encode.sv ----
// Layer-serial LDPC normalization, on-line/final parity check and parity encoder.
// Assumes upstream delivers one layer per handshake: unscaled LLR message, layer syndrome
// bit and, for encode, the layer's information product and known-parity mask.
`timescale 1ns/1ps

module ldpc_norm_parity_encode #(
	parameter bit FINAL_CHECK_BUILT = 1'b1
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Scale table register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [19:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Per-block control
	input wire logic blk_start_i,
	input wire logic blk_encode_i,
	input wire logic blk_mode_5g_i,
	input wire logic [3:0] block_norm_select_i,
	input wire logic blk_early_term_i,
	input wire logic blk_no_final_check_i,
	input wire logic [4:0] blk_layers_i,
	input wire logic [5:0] blk_max_iter_i,
	input wire logic [11:0] blk_code_entries_i,
	input wire logic [4:0] blk_dd_layers_i,
	input wire logic [7:0] blk_scale_base_i,
	output logic blk_busy_o,
	// Layer input
	input wire logic lay_valid_i,
	input wire logic [5:0] lay_msg_i,
	input wire logic lay_syn_i,
	input wire logic [15:0] lay_info_i,
	input wire logic [15:0] lay_mask_i,
	output logic lay_ready_o,
	// Data output
	output logic dout_valid_o,
	output logic [15:0] dout_data_o,
	output logic dout_last_o,
	// Status output
	output logic stat_valid_o,
	output logic stat_pass_o,
	output logic stat_early_o,
	output logic [5:0] stat_iters_o
);

	// ------------------------------------------------------------
	// State and storage
	// ------------------------------------------------------------
	ldpc_norm_parity_pkg::state_e state;
	ldpc_norm_parity_pkg::state_e next_state;
	logic [4:0] scale_tab [ldpc_norm_parity_pkg::SCALE_DEPTH];
	logic [15:0] info_mem [ldpc_norm_parity_pkg::MAX_LAYERS];
	logic [15:0] mask_mem [ldpc_norm_parity_pkg::MAX_LAYERS];
	ldpc_norm_parity_pkg::par_t par;
	logic [15:0] p0_acc;
	logic [3:0] layer;
	logic [5:0] iter;
	logic fail_now;
	logic chk_fail;
	logic signed [15:0] acc;
	logic c_mode_5g;
	logic [3:0] c_sel;
	logic c_early_term;
	logic c_no_final;
	logic [4:0] c_layers;
	logic [5:0] c_max_iter;
	logic [11:0] c_entries;
	logic [4:0] c_dd;
	logic [7:0] c_base;

	// ------------------------------------------------------------
	// Decode of register port and datapath
	// ------------------------------------------------------------
	wire logic reg_hit = (reg_addr_i >= ldpc_norm_parity_pkg::SCALE_TABLE_FIRST) &&
		(reg_addr_i <= ldpc_norm_parity_pkg::SCALE_TABLE_LAST) && (reg_addr_i[1:0] == 2'h0);
	wire logic [19:0] reg_off = reg_addr_i - ldpc_norm_parity_pkg::SCALE_TABLE_FIRST;
	wire logic [7:0] reg_idx = reg_off[9:2];
	wire logic take = lay_ready_o & lay_valid_i;
	wire logic last_layer = ({1'b0, layer} == (c_layers - 5'h01));
	wire logic [7:0] tab_idx = c_base + {4'h0, layer};
	wire logic [4:0] cur_scale = c_mode_5g ? ldpc_norm_parity_pkg::norm_from_select(c_sel)
		: scale_tab[tab_idx];
	wire logic signed [11:0] product = $signed(lay_msg_i) * $signed({1'b0, cur_scale});
	wire logic signed [11:0] scaled = product >>> ldpc_norm_parity_pkg::SCALE_FRAC;
	wire logic iter_fail = fail_now | lay_syn_i;
	// Early stop decided on the iteration that just completed
	wire logic stop_early = c_early_term & ~iter_fail;
	wire logic iter_final = ((iter + 6'h01) >= c_max_iter);
	// Final checker needs build option, no disable, not 5G, small enough code
	wire logic final_chk_on = FINAL_CHECK_BUILT & ~c_no_final
		& ~c_mode_5g
		& (c_entries <= ldpc_norm_parity_pkg::FINAL_CHECK_MAX_ENTRIES);
	wire logic dd_mode = (c_dd != 5'h00);
	wire logic enc_skip = dd_mode & ({1'b0, layer} == (c_dd - 5'h01));
	wire logic [3:0] sol_col = (dd_mode && ({1'b0, layer} < (c_dd - 5'h01))) ? layer + 4'h1 : layer;
	wire logic [15:0] sol_val = info_mem[layer] ^ ldpc_norm_parity_pkg::masked_parity(mask_mem[layer], par);
	wire logic enc_last = last_layer |
		(dd_mode && (c_dd == c_layers) && ({1'b0, layer} == (c_layers - 5'h02)));
	wire logic take_state = (next_state == ldpc_norm_parity_pkg::ST_DEC) ||
		(next_state == ldpc_norm_parity_pkg::ST_CHK) || (next_state == ldpc_norm_parity_pkg::ST_ENC_LOAD);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ldpc_norm_parity_pkg::ST_IDLE: begin
				if (blk_start_i) begin
					next_state = blk_encode_i ? ldpc_norm_parity_pkg::ST_ENC_LOAD : ldpc_norm_parity_pkg::ST_DEC;
				end
			end
			ldpc_norm_parity_pkg::ST_DEC: begin
				if (take && last_layer) begin
					if (stop_early) begin
						next_state = ldpc_norm_parity_pkg::ST_STAT;
					end else if (iter_final) begin
						next_state = final_chk_on ? ldpc_norm_parity_pkg::ST_CHK
							: ldpc_norm_parity_pkg::ST_STAT;
					end
				end
			end
			ldpc_norm_parity_pkg::ST_CHK: begin
				if (take && last_layer) begin
					next_state = ldpc_norm_parity_pkg::ST_STAT;
				end
			end
			ldpc_norm_parity_pkg::ST_ENC_LOAD: begin
				if (take && last_layer) begin
					next_state = dd_mode ? ldpc_norm_parity_pkg::ST_ENC_P0 : ldpc_norm_parity_pkg::ST_ENC_SOLVE;
				end
			end
			ldpc_norm_parity_pkg::ST_ENC_P0: begin
				next_state = ldpc_norm_parity_pkg::ST_ENC_SOLVE;
			end
			ldpc_norm_parity_pkg::ST_ENC_SOLVE: begin
				if (last_layer) begin
					next_state = ldpc_norm_parity_pkg::ST_STAT;
				end
			end
			ldpc_norm_parity_pkg::ST_STAT: begin
				next_state = ldpc_norm_parity_pkg::ST_IDLE;
			end
			default: begin
				next_state = ldpc_norm_parity_pkg::ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Scale table and register read
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < ldpc_norm_parity_pkg::SCALE_DEPTH; i++) begin
				scale_tab[i] <= ldpc_norm_parity_pkg::SCALE_RESET;
			end
		end else if (reg_wr_i && reg_hit) begin
			scale_tab[reg_idx] <= reg_wdata_i[4:0];
		end
	end

	// Unmapped or unaligned reads return zero
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h00000000;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			reg_rdata_o <= (reg_rd_i && reg_hit) ? {27'h0000000, scale_tab[reg_idx]} : 32'h00000000;
		end
	end

	// ------------------------------------------------------------
	// Block control capture and sequencing
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ldpc_norm_parity_pkg::ST_IDLE;
			lay_ready_o <= 1'b0;
			blk_busy_o <= 1'b0;
			c_mode_5g <= 1'b0;
			c_sel <= 4'h0;
			c_early_term <= 1'b0;
			c_no_final <= 1'b0;
			c_layers <= 5'h01;
			c_max_iter <= 6'h01;
			c_entries <= 12'h000;
			c_dd <= 5'h00;
			c_base <= 8'h00;
		end else begin
			state <= next_state;
			lay_ready_o <= take_state;
			blk_busy_o <= (next_state != ldpc_norm_parity_pkg::ST_IDLE);
			if (state == ldpc_norm_parity_pkg::ST_IDLE && blk_start_i) begin
				c_mode_5g <= blk_mode_5g_i;
				c_sel <= block_norm_select_i;
				c_early_term <= blk_early_term_i;
				c_no_final <= blk_no_final_check_i;
				c_layers <= blk_layers_i;
				c_max_iter <= blk_max_iter_i;
				c_entries <= blk_code_entries_i;
				c_dd <= blk_dd_layers_i;
				c_base <= blk_scale_base_i;
			end
		end
	end

	// Layer and iteration counters; solve walks layers without handshake
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			layer <= 4'h0;
			iter <= 6'h00;
		end else if (state == ldpc_norm_parity_pkg::ST_IDLE || state == ldpc_norm_parity_pkg::ST_ENC_P0) begin
			layer <= 4'h0;
			iter <= (state == ldpc_norm_parity_pkg::ST_IDLE) ? 6'h00 : iter;
		end else if (take || state == ldpc_norm_parity_pkg::ST_ENC_SOLVE) begin
			layer <= last_layer ? 4'h0 : layer + 4'h1;
			if (last_layer && state == ldpc_norm_parity_pkg::ST_DEC) begin
				iter <= iter + 6'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Decoder accumulation and parity checks
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc <= 16'sh0000;
			fail_now <= 1'b0;
			chk_fail <= 1'b0;
		end else if (state == ldpc_norm_parity_pkg::ST_IDLE) begin
			acc <= 16'sh0000;
			fail_now <= 1'b0;
			chk_fail <= 1'b0;
		end else if (take && state == ldpc_norm_parity_pkg::ST_DEC) begin
			acc <= acc + {{4{scaled[11]}}, scaled};
			fail_now <= last_layer ? 1'b0 : iter_fail;
		end else if (take && state == ldpc_norm_parity_pkg::ST_CHK) begin
			chk_fail <= chk_fail | lay_syn_i;
		end
	end

	// ------------------------------------------------------------
	// Encoder storage and solve
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < ldpc_norm_parity_pkg::MAX_LAYERS; i++) begin
				info_mem[i] <= 16'h0000;
				mask_mem[i] <= 16'h0000;
			end
			par <= '0;
			p0_acc <= 16'h0000;
		end else if (state == ldpc_norm_parity_pkg::ST_IDLE) begin
			par <= '0;
			p0_acc <= 16'h0000;
		end else if (take && state == ldpc_norm_parity_pkg::ST_ENC_LOAD) begin
			info_mem[layer] <= lay_info_i;
			mask_mem[layer] <= lay_mask_i;
			// Known parity terms cancel in the double-diagonal sum
			if ({1'b0, layer} < c_dd) begin
				p0_acc <= p0_acc ^ lay_info_i;
			end
		end else if (state == ldpc_norm_parity_pkg::ST_ENC_P0) begin
			par[0] <= p0_acc;
		end else if (state == ldpc_norm_parity_pkg::ST_ENC_SOLVE && !enc_skip) begin
			par[sol_col] <= sol_val;
		end
	end

	// ------------------------------------------------------------
	// Data and status outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dout_valid_o <= 1'b0;
			dout_data_o <= 16'h0000;
			dout_last_o <= 1'b0;
		end else begin
			dout_valid_o <= 1'b0;
			dout_last_o <= 1'b0;
			if (take && state == ldpc_norm_parity_pkg::ST_DEC && last_layer && (stop_early || iter_final)) begin
				// Decision goes out while the final check is still running
				dout_valid_o <= 1'b1;
				dout_last_o <= 1'b1;
				dout_data_o <= acc + {{4{scaled[11]}}, scaled};
			end else if (state == ldpc_norm_parity_pkg::ST_ENC_P0) begin
				dout_valid_o <= 1'b1;
				dout_last_o <= (c_layers == 5'h01);
				dout_data_o <= p0_acc;
			end else if (state == ldpc_norm_parity_pkg::ST_ENC_SOLVE && !enc_skip) begin
				dout_valid_o <= 1'b1;
				dout_last_o <= enc_last;
				dout_data_o <= sol_val;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_valid_o <= 1'b0;
			stat_pass_o <= 1'b0;
			stat_early_o <= 1'b0;
			stat_iters_o <= 6'h00;
		end else begin
			stat_valid_o <= 1'b0;
			if (state == ldpc_norm_parity_pkg::ST_STAT) begin
				stat_valid_o <= 1'b1;
			end
			if (take && state == ldpc_norm_parity_pkg::ST_DEC && last_layer) begin
				stat_iters_o <= iter + 6'h01;
				stat_early_o <= stop_early;
				stat_pass_o <= ~iter_fail;
			end else if (take && state == ldpc_norm_parity_pkg::ST_CHK && last_layer) begin
				stat_pass_o <= ~(chk_fail | lay_syn_i);
			end else if (state == ldpc_norm_parity_pkg::ST_ENC_LOAD) begin
				stat_iters_o <= 6'h01;
				stat_early_o <= 1'b0;
				stat_pass_o <= 1'b1;
			end
		end
	end

endmodule : ldpc_norm_parity_encode

// ---- sim/ldpc_norm_parity_encode_chk.sv ----
// Port-level checker for the LDPC normalization, parity check and encode block.
// Bound to every instance of the block; sees its ports and nothing else.
`timescale 1ns/1ps

module ldpc_norm_parity_encode_chk #(
	parameter bit FINAL_CHECK_BUILT = 1'b1
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic reg_rd_i,
	input wire logic [19:0] reg_addr_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	// Block control and layers
	input wire logic blk_start_i,
	input wire logic blk_encode_i,
	input wire logic blk_mode_5g_i,
	input wire logic blk_no_final_check_i,
	input wire logic [11:0] blk_code_entries_i,
	input wire logic blk_busy_o,
	input wire logic lay_ready_o,
	// Data and status
	input wire logic dout_valid_o,
	input wire logic dout_last_o,
	input wire logic stat_valid_o,
	input wire logic stat_pass_o,
	input wire logic stat_early_o,
	input wire logic [5:0] stat_iters_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	logic enc;
	logic chk_on;
	logic chk_off;
	logic take;
	logic fin_on;
	assign take = blk_start_i && !blk_busy_o;
	assign fin_on = FINAL_CHECK_BUILT && !blk_mode_5g_i && !blk_no_final_check_i &&
		blk_code_entries_i <= ldpc_norm_parity_pkg::FINAL_CHECK_MAX_ENTRIES;
	// Block kind held from start until the next start
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			enc <= 1'b0;
			chk_on <= 1'b0;
			chk_off <= 1'b0;
		end else if (take) begin
			enc <= blk_encode_i;
			chk_on <= !blk_encode_i && fin_on;
			chk_off <= !blk_encode_i && !fin_on;
		end
	end
	rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
	rd_quiet_a: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("spurious read valid");
	unmapped_zero_a: assert property (reg_rd_i && (reg_addr_i > ldpc_norm_parity_pkg::SCALE_TABLE_LAST ||
		reg_addr_i < ldpc_norm_parity_pkg::SCALE_TABLE_FIRST || reg_addr_i[1:0] != 2'h0) |=> reg_rdata_o == 32'h0)
		else $error("unmapped read not zero");
	start_ready_a: assert property (take |=> blk_busy_o && lay_ready_o) else $error("start not taken");
	busy_drop_a: assert property (stat_valid_o |-> !blk_busy_o && $past(blk_busy_o)) else $error("busy misaligned");
	idle_ready_a: assert property (!blk_busy_o |-> !lay_ready_o) else $error("ready while idle");
	dout_busy_a: assert property (dout_valid_o |-> blk_busy_o) else $error("data outside block");
	early_pass_a: assert property (stat_valid_o && stat_early_o |-> stat_pass_o) else $error("early without pass");
	no_check_a: assert property (chk_off && dout_last_o |=> stat_valid_o) else $error("status held");
	check_hold_a: assert property (chk_on && stat_valid_o && !stat_early_o |->
		!$past(dout_last_o) && !$past(dout_last_o, 2)) else $error("final check skipped");
	last_stat_a: assert property (dout_last_o |-> ##[1:300] stat_valid_o) else $error("status missing");
	enc_stat_a: assert property (enc && stat_valid_o |->
		stat_pass_o && !stat_early_o && stat_iters_o == 6'h01) else $error("encode status wrong");
	cover property (enc && stat_valid_o);
	cover property (stat_valid_o && stat_early_o && stat_iters_o == 6'h02);
	cover property (stat_valid_o && stat_early_o);
	cover property (chk_on && stat_valid_o && !stat_pass_o);
endmodule : ldpc_norm_parity_encode_chk

bind ldpc_norm_parity_encode ldpc_norm_parity_encode_chk #(.FINAL_CHECK_BUILT(FINAL_CHECK_BUILT)) i_chk (.*);

// ---- sim/ldpc_layer_source.sv ----
// Upstream layer source: presents queued layers on the valid/ready handshake.
// Entry bits: [40] syndrome, [39:32] LLR, [31:16] info product, [15:0] known-parity mask.
`timescale 1ns/1ps

module ldpc_layer_source (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Random stalls when high
	input wire logic slow_i,
	// Layer handshake
	input wire logic ready_i,
	output logic valid_o,
	output logic [5:0] msg_o,
	output logic syn_o,
	output logic [15:0] info_o,
	output logic [15:0] mask_o
);
	logic [40:0] q[$];
	logic [40:0] cur;
	logic signed [7:0] raw;
	logic nv;
	assign raw = cur[39:32];
	// Symmetric clamp so -32 never reaches the core
	assign msg_o = raw > 8'sd31 ? 6'h1F : raw < -8'sd31 ? 6'h21 : raw[5:0];
	assign syn_o = cur[40];
	assign info_o = cur[31:16];
	assign mask_o = cur[15:0];
	// Idle lines toggle so stale data never looks valid
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			valid_o <= 1'b0;
			cur <= 41'h0;
		end else begin
			if (valid_o && ready_i)
				void'(q.pop_front());
			nv = (valid_o && !ready_i) || (q.size() != 0 && !(slow_i && $urandom_range(1) == 1));
			valid_o <= nv;
			cur <= nv ? q[0] : ~cur;
		end
	end
endmodule : ldpc_layer_source

// ---- sim/ldpc_norm_parity_encode_tb.sv ----
// Self-checking bench for the LDPC normalization, parity check and encode block.
// Assumes the layer source model and the bound checker are compiled with it.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module ldpc_norm_parity_encode_tb;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic blk_start_i = 1'b0;
	logic slow = 1'b0;
	logic [19:0] reg_addr_i = '0;
	logic [31:0] reg_wdata_i = '0;
	logic [43:0] ctl = '0;
	wire logic blk_encode_i, blk_mode_5g_i, blk_early_term_i, blk_no_final_check_i;
	wire logic [3:0] block_norm_select_i;
	wire logic [4:0] blk_layers_i, blk_dd_layers_i;
	wire logic [5:0] blk_max_iter_i;
	wire logic [11:0] blk_code_entries_i;
	wire logic [7:0] blk_scale_base_i;
	logic [31:0] reg_rdata_o;
	logic reg_rvalid_o, blk_busy_o, lay_valid_i, lay_syn_i, lay_ready_o;
	logic [5:0] lay_msg_i, stat_iters_o;
	logic [15:0] lay_info_i, lay_mask_i, dout_data_o;
	logic dout_valid_o, dout_last_o, stat_valid_o, stat_pass_o, stat_early_o;
	logic [16:0] qd[$];
	logic [7:0] qs[$];
	logic [31:0] qr[$];
	logic [4:0] tbl[256];
	logic [31:0] ex;
	int err_count = 0;
	int comparisons = 0;
	int cyc = 0;
	assign {blk_encode_i, blk_mode_5g_i, block_norm_select_i, blk_early_term_i, blk_no_final_check_i, blk_layers_i,
		blk_max_iter_i, blk_code_entries_i, blk_dd_layers_i, blk_scale_base_i} = ctl;

	ldpc_norm_parity_encode i_dut (.*);
	ldpc_layer_source i_src (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .slow_i(slow), .ready_i(lay_ready_o),
		.valid_o(lay_valid_i), .msg_o(lay_msg_i), .syn_o(lay_syn_i), .info_o(lay_info_i), .mask_o(lay_mask_i));

	initial begin
		forever #4 mclk_i = ~mclk_i;
	end
	// ----
	// Scoreboard: results checked mid-cycle against the oldest note
	// ----
	always @(negedge mclk_i) begin
		if (reg_rvalid_o) begin ex = qr.pop_front(); `CHK(reg_rdata_o, ex) end
		if (dout_valid_o) begin ex = qd.pop_front(); `CHK({dout_last_o, dout_data_o}, ex[16:0]) end
		if (stat_valid_o) begin ex = qs.pop_front(); `CHK({stat_pass_o, stat_early_o, stat_iters_o}, ex[7:0]) end
	end
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
	end

	task automatic summarize;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	task automatic rw(input logic w, input logic [19:0] a, input logic [31:0] d);
		logic ok;
		ok = a >= 20'h10000 && a <= 20'h103FC && a[1:0] == 2'h0;
		@(posedge mclk_i);
		#1;
		reg_wr_i = w;
		reg_rd_i = !w;
		reg_addr_i = a;
		reg_wdata_i = d;
		if (w && ok)
			tbl[a[9:2]] = d[4:0];
		if (!w)
			qr.push_back(ok ? {27'h0, tbl[a[9:2]]} : 32'h0);
	endtask : rw

	task automatic go(input logic [43:0] c);
		@(posedge mclk_i);
		#1;
		ctl = c;
		blk_start_i = 1'b1;
		@(posedge mclk_i);
		#1;
		blk_start_i = 1'b0;
		while (blk_busy_o !== 1'b0) begin
			@(posedge mclk_i);
			#1;
		end
	endtask : go

	task automatic dec(input logic g5, input logic et, input logic nf, input logic [11:0] ent, input int n, input int fail);
		logic [3:0] sel;
		logic [7:0] base;
		logic chk;
		int acc;
		int m;
		int s;
		int it;
		sel = 4'($urandom);
		base = 8'($urandom);
		slow = 1'($urandom);
		// Early stop skips the final check, so no check pass is fed then
		chk = !et && !g5 && !nf && ent <= 12'h400;
		// A failing first iteration under early termination forces a second one
		it = (et && fail >= 0 && fail < n) ? 2 : 1;
		acc = 0;
		for (int l = 0; l < it * n; l++) begin
			m = $urandom_range(62) - 31;
			s = g5 ? sel + 1 : tbl[8'(base + l % n)];
			acc += (m * s) >>> 4;
			i_src.q.push_back({l == fail, 8'(m), 32'h0});
		end
		for (int l = 0; l < n && chk; l++)
			i_src.q.push_back({it * n + l == fail, 40'h0});
		qd.push_back({1'b1, 16'(acc)});
		qs.push_back({chk ? fail < n : (fail < (it - 1) * n || fail >= it * n), et, 6'(it)});
		go({1'b0, g5, sel, et, nf, 5'(n), et ? 6'h03 : 6'h01, ent, 5'h00, base});
	endtask : dec

	task automatic enc(input int n, input int dd);
		logic [15:0] inf[16];
		logic [15:0] p[16];
		logic [15:0] msk;
		int c;
		p[0] = 16'h0000;
		slow = 1'($urandom);
		for (int l = 0; l < n; l++) begin
			inf[l] = 16'($urandom);
			if (l < dd)
				p[0] ^= inf[l];
		end
		for (int l = 0; l < n; l++) begin
			c = dd == 0 || l >= dd ? l : l < dd - 1 ? l + 1 : -1;
			msk = c > 0 ? 16'($urandom) & ((16'h1 << c) - 16'h1) : 16'h0000;
			if (c >= 0)
				p[c] = inf[l];
			for (int j = 0; j < 16; j++)
				if (msk[j])
					p[c] ^= p[j];
			i_src.q.push_back({9'h000, inf[l], msk});
		end
		for (int l = 0; l < n; l++)
			qd.push_back({l == n - 1, p[l]});
		qs.push_back(8'h81);
		go({1'b1, 1'b0, 4'h0, 2'b00, 5'(n), 6'h01, 12'h010, 5'(dd), 8'h00});
	endtask : enc

	initial begin
		logic [19:0] a;
		for (int i = 0; i < 256; i++)
			tbl[i] = 5'h0C;
		void'($urandom(27640));
		repeat (8) @(posedge mclk_i);
		#1;
		rst_n_i = 1'b1;
		rw(1'b0, 20'h10000, 32'h0);
		rw(1'b0, 20'h103FC, 32'h0);
		// Mix of unmapped, unaligned and table addresses
		repeat (150) begin
			a = 20'h0FF00 + 20'($urandom_range(1535));
			rw(1'b1, a, $urandom);
			rw(1'b0, a, 32'h0);
		end
		@(posedge mclk_i);
		#1;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		dec(1'b0, 1'b0, 1'b1, 12'h010, 3, 1);
		dec(1'b0, 1'b1, 1'b1, 12'h010, 4, -1);
		dec(1'b0, 1'b1, 1'b1, 12'h010, 3, 1);
		repeat (4) dec(1'b1, 1'b0, 1'b0, 12'h010, 2, $urandom_range(1) - 1);
		dec(1'b0, 1'b0, 1'b0, 12'h010, 3, 4);
		dec(1'b0, 1'b0, 1'b0, 12'h010, 2, 0);
		dec(1'b0, 1'b0, 1'b0, 12'h400, 2, -1);
		dec(1'b0, 1'b0, 1'b0, 12'h401, 2, 0);
		enc(3, 0);
		enc(16, 0);
		enc(4, 2);
		enc(5, 5);
		enc(16, 3);
		repeat (4) @(posedge mclk_i);
		`CHK(qd.size() + qs.size() + qr.size(), 0)
		summarize();
	end
endmodule : ldpc_norm_parity_encode_tb
